// >>> bench/sbg_bus_partner.sv
/*
 * Far-side model: system bus slave acknowledge and master cascade lines.
 * Assumes arb_en follows the glue's arbiter enable, all on mclk.
 */
`timescale 1ns/100ps

module sbg_bus_partner
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       srst,
   // control from bench and glue
   input  wire logic       arb_en,
   input  wire logic [3:0] ack_dly,
   input  wire logic [2:0] casc_code,
   // far-side lines
   output logic            xack_n,
   output logic            cas_b0,
   output logic            cas_b1,
   output logic            cas_b2
);
   logic [3:0] cnt_r;

   // =====================================================================
   // slave: acknowledge after ack_dly cycles, zero means no slave
   always_ff @(posedge mclk)
   begin
      if (srst || !arb_en)
         cnt_r <= 4'h0;
      else if (cnt_r != 4'hF)
         cnt_r <= cnt_r + 4'h1;
   end
   // pulled up when released
   assign xack_n = !(arb_en && ack_dly != 4'h0 && cnt_r >= ack_dly);

   // =====================================================================
   // master controller cascade lines, active low
   assign cas_b0 = ~casc_code[0];
   assign cas_b1 = ~casc_code[1];
   assign cas_b2 = ~casc_code[2];
endmodule

// >>> bench/testbench.sv
/*
 * Self-checking bench of the system bus glue.
 * Assumes sbg_glue and sbg_bus_partner; inputs change on falling edges.
 */
`timescale 1ns/100ps
`include "sbg_defines.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t mismatch", $time); end end

module testbench;
   import sbg_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, stb_n = 1'b1, sys = 1'b0, iack_n = 1'b1;
   logic bhs_n = 1'b1, a0 = 1'b0, pfin_n = 1'b1, pfsn_n = 1'b1, pfs_clr = 1'b0;
   logic [7:0] slaves = 8'h00;
   logic [3:0] dly = 4'h1;
   logic [2:0] code = 3'h0;
   sbg_route_e route = SBG_ROUTE_LOCAL;
   logic xack_n, c0, c1, c2, rdy_n, hwb_n, nmi, arb, bsel, cdrv, coe, ldir, lswp, tmo, pfs, pfsr;
   logic [2:0] caddr;
   int fails = 0, checks = 0, n;

   sbg_glue #(.TIMEOUT_CYC(50)) u_sbg_glue (.mclk(mclk), .srst(srst), .cfg_route(route),
      .cfg_sys_slaves(slaves), .addr_strobe_n(stb_n), .sys_cycle(sys),
      .irq_ack_strobe_n(iack_n), .byte_high_sel_n(bhs_n), .addr_a0(a0),
      .ready_n_r(rdy_n), .half_width_bus_n_r(hwb_n), .nmi_req_r(nmi),
      .cascade_sel_bit0(c0), .cascade_sel_bit1(c1), .cascade_sel_bit2(c2),
      .xack_n(xack_n), .pfin_n(pfin_n), .pfsn_n(pfsn_n), .pfs_clear_req(pfs_clr),
      .arb_en_r(arb), .bus_sel_sys_r(bsel), .master_cascade_drive_en_r(cdrv),
      .casc_addr_o_r(caddr), .casc_addr_oe_r(coe), .lane_direct_oe_n_r(ldir),
      .lane_swap_oe_n_r(lswp), .timeout_r(tmo), .pwr_fail_seen_r(pfs), .pfsr_n_r(pfsr));
   sbg_bus_partner u_sbg_bus_partner (.mclk(mclk), .srst(srst), .arb_en(arb),
      .ack_dly(dly), .casc_code(code), .xack_n(xack_n), .cas_b0(c0), .cas_b1(c1),
      .cas_b2(c2));

   // =====================================================================
   // clock and watchdog
   initial
   begin
      forever #25 mclk = ~mclk;
   end
   initial
   begin
      #200000;
      fails++;
      give_verdict();
   end

   // =====================================================================
   // shared tasks
   task automatic bus(input logic s, input logic ia);
      @(negedge mclk);
      stb_n = 1'b0;
      sys = s;
      iack_n = ia;
      @(negedge mclk);
      stb_n = 1'b1;
      iack_n = 1'b1;
   endtask
   task automatic wait_rdy();
      n = 0;
      while (rdy_n !== 1'b0 && n < 200)
      begin
         @(negedge mclk);
         n++;
      end
   endtask

   // =====================================================================
   // scenarios
   task automatic sys_xfer(input logic bh, input logic a, input logic [3:0] d);
      bhs_n = bh;
      a0 = a;
      dly = d;
      bus(1'b1, 1'b1);
      @(negedge mclk);
      `CHK(arb, 1'b1)
      `CHK(hwb_n, 1'b0)
      `CHK(lswp, !(!bh && a))
      `CHK(ldir, !bh && a)
      wait_rdy();
      `CHK(n >= d && n < 200, 1'b1)
      `CHK(arb, 1'b0)
   endtask
   task automatic tmo_xfer();
      dly = 4'h0;
      bus(1'b1, 1'b1);
      wait_rdy();
      `CHK(tmo, 1'b1)
      `CHK(n >= 50 && n < 200, 1'b1)
      @(negedge mclk);
      @(negedge mclk);
      `CHK(tmo, 1'b0)
   endtask
   task automatic irq_ack(input sbg_route_e r, input logic [7:0] sl, input logic [2:0] c,
                          input logic ex);
      route = r;
      slaves = sl;
      code = c;
      dly = 4'h2;
      bus(1'b0, 1'b0);
      wait_rdy();
      `CHK(n, `SBG_ACK1_WAIT_CYC)
      `CHK(bsel, ex)
      `CHK(caddr, c)
      repeat (8) @(negedge mclk);
      bus(1'b0, 1'b0);
      @(negedge mclk);
      `CHK(cdrv, ex)
      `CHK(coe, ex)
      wait_rdy();
      `CHK(n < 200, ex)
      @(negedge mclk);
      `CHK(cdrv, 1'b0)
   endtask
   task automatic power();
      pfin_n = 1'b0;
      pfsn_n = 1'b0;
      pfs_clr = 1'b1;
      repeat (2) @(negedge mclk);
      `CHK(nmi, 1'b1)
      `CHK(pfs, 1'b1)
      `CHK(pfsr, 1'b0)
      pfin_n = 1'b1;
      pfsn_n = 1'b1;
      pfs_clr = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK(nmi, 1'b0)
      `CHK(pfs, 1'b0)
      `CHK(pfsr, 1'b1)
   endtask

   task automatic give_verdict();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // =====================================================================
   // main sequence
   initial
   begin
      repeat (5) @(negedge mclk);
      `CHK(tmo, 1'b0)
      srst = 1'b0;
      sys_xfer(1'b0, 1'b1, 4'h3);
      sys_xfer(1'b1, 1'b0, 4'h1);
      sys_xfer(1'b0, 1'b0, 4'h2);
      tmo_xfer();
      sys_xfer(1'b0, 1'b1, 4'h4);
      irq_ack(SBG_ROUTE_LOCAL, 8'hFF, 3'h5, 1'b0);
      irq_ack(SBG_ROUTE_SYSTEM, 8'h00, 3'h6, 1'b1);
      irq_ack(SBG_ROUTE_MIXED, 8'h0A, 3'h3, 1'b1);
      irq_ack(SBG_ROUTE_MIXED, 8'h0A, 3'h2, 1'b0);
      power();
      give_verdict();
   end
endmodule

// >>> src/sbg_defines.svh
/*
 * Constants of the system bus glue: timing figures and derived cycle counts.
 * Assumes a single 20 MHz processor clock; included by src/sbg_glue.sv.
 */
`ifndef SBG_DEFINES_SVH
`define SBG_DEFINES_SVH

// =====================================================================
// clock
`define SBG_CLK_NS            50
// =====================================================================
// interrupt-acknowledge settle budget
`define SBG_CAS_VALID_NS      565
`define SBG_DECODE_NS         30
`define SBG_IDLE_BUS_CYC      4
`define SBG_CLK_PER_BUS_CYC   2
`define SBG_SETTLE_CYC        ((`SBG_CAS_VALID_NS + `SBG_DECODE_NS + `SBG_CLK_NS - 1) / `SBG_CLK_NS)
`define SBG_ACK1_RAW_CYC      (`SBG_SETTLE_CYC - `SBG_IDLE_BUS_CYC * `SBG_CLK_PER_BUS_CYC)
`define SBG_ACK1_WAIT_CYC     ((`SBG_ACK1_RAW_CYC < 1) ? 1 : `SBG_ACK1_RAW_CYC)
// =====================================================================
// bus timeout
`define SBG_TIMEOUT_NS        1000000
`define SBG_TIMEOUT_CYC       (`SBG_TIMEOUT_NS / `SBG_CLK_NS)
// =====================================================================
// reset values
`define SBG_CAS_RST           3'h0

`endif

// >>> src/sbg_glue.sv
/*
 * System bus glue: interrupt-acknowledge bus select, cascade address drive,
 * byte lane steering, ready generation with bus timeout, power-fail lines.
 * Assumes all inputs are synchronous to mclk and the address strobe is a
 * one-cycle active-low pulse per bus cycle.
 */
`timescale 1ns/100ps
`include "sbg_defines.svh"

module sbg_glue
#(
   parameter int TIMEOUT_CYC = `SBG_TIMEOUT_CYC
)
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              srst,
   // configuration
   input  wire sbg_pkg::sbg_route_e cfg_route,
   input  wire logic [7:0]        cfg_sys_slaves,
   // processor side
   input  wire logic              addr_strobe_n,
   input  wire logic              sys_cycle,
   input  wire logic              irq_ack_strobe_n,
   input  wire logic              byte_high_sel_n,
   input  wire logic              addr_a0,
   output logic                   ready_n_r,
   output logic                   half_width_bus_n_r,
   output logic                   nmi_req_r,
   // master interrupt controller cascade lines
   input  wire logic              cascade_sel_bit0,
   input  wire logic              cascade_sel_bit1,
   input  wire logic              cascade_sel_bit2,
   // system bus side
   input  wire logic              xack_n,
   input  wire logic              pfin_n,
   input  wire logic              pfsn_n,
   input  wire logic              pfs_clear_req,
   output logic                   arb_en_r,
   output logic                   bus_sel_sys_r,
   output logic                   master_cascade_drive_en_r,
   output logic [2:0]             casc_addr_o_r,
   output logic                   casc_addr_oe_r,
   output logic                   lane_direct_oe_n_r,
   output logic                   lane_swap_oe_n_r,
   output logic                   timeout_r,
   output logic                   pwr_fail_seen_r,
   output logic                   pfsr_n_r
);
   import sbg_pkg::*;

   localparam int TMO_W    = $clog2(TIMEOUT_CYC + 1);
   localparam int ACK1_CYC = `SBG_ACK1_WAIT_CYC;

   sbg_state_e       state_r, state_nxt;
   logic [TMO_W-1:0] cnt_r, cnt_nxt;
   logic             second_r, second_nxt;
   logic             ready_n_nxt, timeout_nxt, bus_sel_nxt, cdrv_nxt;
   logic             arb_en_nxt, hwb_n_nxt, dir_oe_n_nxt, swp_oe_n_nxt;
   logic [2:0]       casc_nxt, cas_code;
   logic             cas_is_sys, cyc_ends, tmo_hit;

   // =====================================================================
   // cascade decode
   always_comb
   begin
      cas_code = ~{cascade_sel_bit2, cascade_sel_bit1, cascade_sel_bit0};
      case (cfg_route)
         SBG_ROUTE_LOCAL:  cas_is_sys = 1'b0;
         SBG_ROUTE_SYSTEM: cas_is_sys = 1'b1;
         SBG_ROUTE_MIXED:  cas_is_sys = cfg_sys_slaves[cas_code];
         default:          cas_is_sys = 1'b0;
      endcase
   end

   // =====================================================================
   // cycle sequencer, ready and timeout
   always_comb
   begin
      state_nxt    = state_r;
      cnt_nxt      = cnt_r;
      second_nxt   = second_r;
      ready_n_nxt  = 1'b1;
      bus_sel_nxt  = bus_sel_sys_r;
      casc_nxt     = casc_addr_o_r;
      dir_oe_n_nxt = lane_direct_oe_n_r;
      swp_oe_n_nxt = lane_swap_oe_n_r;
      cyc_ends     = 1'b0;
      tmo_hit      = 1'b0;
      case (state_r)
         SBG_ST_IDLE:
         begin
            cnt_nxt = '0;
            if (!addr_strobe_n && !irq_ack_strobe_n)
            begin
               if (!second_r)
                  state_nxt = SBG_ST_ACK1;
               else if (bus_sel_sys_r)
                  state_nxt = SBG_ST_ACK2;
               else
                  second_nxt = 1'b0;
            end
            else if (!addr_strobe_n && sys_cycle)
            begin
               state_nxt = SBG_ST_SYS;
               // odd byte alone sits on D15-D8 and goes to the low lane
               swp_oe_n_nxt = ~(!byte_high_sel_n && addr_a0);
               dir_oe_n_nxt = ~swp_oe_n_nxt;
            end
         end
         SBG_ST_ACK1:
         begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == TMO_W'(ACK1_CYC - 1))
            begin
               bus_sel_nxt = cas_is_sys;
               casc_nxt    = cas_code;
               ready_n_nxt = 1'b0;
               second_nxt  = 1'b1;
               state_nxt   = SBG_ST_IDLE;
            end
         end
         SBG_ST_SYS, SBG_ST_ACK2:
         begin
            cnt_nxt = cnt_r + 1'b1;
            if (!xack_n || timeout_r)
            begin
               cyc_ends    = 1'b1;
               ready_n_nxt = 1'b0;
               state_nxt   = SBG_ST_IDLE;
               if (state_r == SBG_ST_ACK2)
                  second_nxt = 1'b0;
            end
            else if (cnt_r == TMO_W'(TIMEOUT_CYC - 1))
               tmo_hit = 1'b1;
         end
         default:
            state_nxt = SBG_ST_IDLE;
      endcase
      // set wins over the clear
      if (tmo_hit)
         timeout_nxt = 1'b1;
      else if (!ready_n_r)
         timeout_nxt = 1'b0;
      else
         timeout_nxt = timeout_r;
      arb_en_nxt = (state_nxt == SBG_ST_SYS) || (state_nxt == SBG_ST_ACK2);
      hwb_n_nxt  = ~arb_en_nxt;
      cdrv_nxt   = (state_nxt == SBG_ST_ACK2) && !cyc_ends;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         state_r                   <= SBG_ST_IDLE;
         cnt_r                     <= '0;
         second_r                  <= 1'b0;
         ready_n_r                 <= 1'b1;
         timeout_r                 <= 1'b0;
         bus_sel_sys_r             <= 1'b0;
         casc_addr_o_r             <= `SBG_CAS_RST;
         casc_addr_oe_r            <= 1'b0;
         master_cascade_drive_en_r <= 1'b0;
         arb_en_r                  <= 1'b0;
         half_width_bus_n_r        <= 1'b1;
         lane_direct_oe_n_r        <= 1'b1;
         lane_swap_oe_n_r          <= 1'b1;
      end
      else
      begin
         state_r                   <= state_nxt;
         cnt_r                     <= cnt_nxt;
         second_r                  <= second_nxt;
         ready_n_r                 <= ready_n_nxt;
         timeout_r                 <= timeout_nxt;
         bus_sel_sys_r             <= bus_sel_nxt;
         casc_addr_o_r             <= casc_nxt;
         casc_addr_oe_r            <= cdrv_nxt;
         master_cascade_drive_en_r <= cdrv_nxt;
         arb_en_r                  <= arb_en_nxt;
         half_width_bus_n_r        <= hwb_n_nxt;
         lane_direct_oe_n_r        <= arb_en_nxt ? dir_oe_n_nxt : 1'b1;
         lane_swap_oe_n_r          <= arb_en_nxt ? swp_oe_n_nxt : 1'b1;
      end
   end

   // =====================================================================
   // power-fail lines
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         nmi_req_r       <= 1'b0;
         pwr_fail_seen_r <= 1'b0;
         pfsr_n_r        <= 1'b1;
      end
      else
      begin
         nmi_req_r       <= ~pfin_n;
         pwr_fail_seen_r <= ~pfsn_n;
         pfsr_n_r        <= ~pfs_clear_req;
      end
   end

   // =====================================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_route_local: assert property ((state_r == SBG_ST_ACK1) && (cfg_route == SBG_ROUTE_LOCAL)
      && (cnt_r == TMO_W'(ACK1_CYC - 1)) |=> !bus_sel_sys_r)
      else $error("local mode routed acknowledge to system bus");
   a_route_sys: assert property ((state_r == SBG_ST_ACK1) && (cfg_route == SBG_ROUTE_SYSTEM)
      && (cnt_r == TMO_W'(ACK1_CYC - 1)) |=> bus_sel_sys_r)
      else $error("system mode routed acknowledge to local bus");
   a_arb_start: assert property ($rose(arb_en_r) |-> $past(!addr_strobe_n))
      else $error("arbiter enabled without address strobe");
   a_ack1_wait: assert property ($rose(state_r == SBG_ST_ACK1) |-> ready_n_r [*4]
      ##1 !ready_n_r)
      else $error("first acknowledge wait count wrong");
   a_casc_hold: assert property (master_cascade_drive_en_r && $past(master_cascade_drive_en_r)
      |-> casc_addr_oe_r && $stable(casc_addr_o_r))
      else $error("cascade address moved while driven");
   a_cdrv_drop: assert property (!ready_n_r |-> !master_cascade_drive_en_r)
      else $error("cascade drive still on at cycle end");
   a_no_early: assert property ($fell(ready_n_r) && $past(state_r == SBG_ST_SYS)
      |-> $past(!xack_n || timeout_r))
      else $error("system cycle ended without acknowledge");
   a_hwb_sys: assert property (state_r == SBG_ST_SYS |-> !half_width_bus_n_r)
      else $error("half-width indication missing on system cycle");
   a_swap_odd: assert property (!lane_swap_oe_n_r |-> lane_direct_oe_n_r && arb_en_r)
      else $error("both byte paths enabled");
   a_tmo_set: assert property ((state_r == SBG_ST_SYS) && xack_n && !timeout_r
      && (cnt_r == TMO_W'(TIMEOUT_CYC - 1)) |=> timeout_r ##1 !ready_n_r)
      else $error("timeout did not force ready");
   a_tmo_clear: assert property (!ready_n_r |=> !timeout_r)
      else $error("timeout not cleared by ready");
   a_nmi_path: assert property (!pfin_n |=> nmi_req_r)
      else $error("power-fail interrupt not forwarded");

   c_sys_cycle: cover property ($fell(ready_n_r) && $past(state_r == SBG_ST_SYS));
   c_ack2_sys:  cover property (master_cascade_drive_en_r ##[1:50] !ready_n_r);
   c_timeout:   cover property ($rose(timeout_r));
   c_swap:      cover property (!lane_swap_oe_n_r);

endmodule

// >>> src/sbg_pkg.sv
/*
 * Types of the system bus glue: routing modes and cycle states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sbg_pkg;

   // =====================================================================
   // interrupt controller placement
   typedef enum logic [1:0]
   {
      SBG_ROUTE_LOCAL,
      SBG_ROUTE_SYSTEM,
      SBG_ROUTE_MIXED
   } sbg_route_e;

   // =====================================================================
   // cycle sequencer
   typedef enum logic [2:0]
   {
      SBG_ST_IDLE,
      SBG_ST_SYS,
      SBG_ST_ACK1,
      SBG_ST_ACK2
   } sbg_state_e;

endpackage
